// file: include/pfm_pkg.sv
// pin function and mode select: constants, field layouts and carrier types
// assumes a 12-bit APB byte address window; upper address bits are decoded elsewhere
package pfm_pkg;

	// ------------------------------------------------------------------
	// bus and register map
	// ------------------------------------------------------------------
	localparam int          PFM_AW        = 12;
	localparam int          PFM_DW        = 32;
	localparam int          PFM_NPIN      = 3;
	localparam int          PFM_FIRST_PIN = 4;
	// printed offsets are not all word aligned, so each is a register index
	// and the byte address is four times its low ten bits
	localparam logic [31:0] PFM_IDX_PIN4  = 32'h5000300E;
	localparam logic [31:0] PFM_IDX_PIN5  = 32'h50003010;
	localparam logic [31:0] PFM_IDX_PIN6  = 32'h50003012;
	localparam int          PFM_IDX_BITS  = 10;

	// ------------------------------------------------------------------
	// mode register fields
	// ------------------------------------------------------------------
	localparam int         PFM_PULL_LSB   = 8;
	localparam int         PFM_PULL_MSB   = 9;
	localparam int         PFM_FUNC_LSB   = 0;
	localparam int         PFM_FUNC_MSB   = 4;
	localparam logic [1:0] PFM_PULL_NONE  = 2'h0;
	localparam logic [1:0] PFM_PULL_UP    = 2'h1;
	localparam logic [1:0] PFM_PULL_DOWN  = 2'h2;
	localparam logic [1:0] PFM_PULL_OUT   = 2'h3;
	localparam logic [1:0] PFM_PULL_RST   = 2'h2;
	localparam logic [4:0] PFM_FUNC_RST   = 5'h00;
	// analog connection is only possible on pins 3 down to 0 of the port
	localparam int         PFM_ANALOG_MAX_PIN = 3;
	localparam int         PFM_DIAG_MAX_PIN   = 7;

	// ------------------------------------------------------------------
	// function select codes
	// ------------------------------------------------------------------
	localparam logic [4:0] PFM_F_GPIO      = 5'h00;
	localparam logic [4:0] PFM_F_U1_RX     = 5'h01;
	localparam logic [4:0] PFM_F_U1_TX     = 5'h02;
	localparam logic [4:0] PFM_F_U2_RX     = 5'h03;
	localparam logic [4:0] PFM_F_U2_TX     = 5'h04;
	localparam logic [4:0] PFM_F_SP_DI     = 5'h05;
	localparam logic [4:0] PFM_F_SP_DO     = 5'h06;
	localparam logic [4:0] PFM_F_SP_CLK    = 5'h07;
	localparam logic [4:0] PFM_F_SP_EN     = 5'h08;
	localparam logic [4:0] PFM_F_I2C_CLK   = 5'h09;
	localparam logic [4:0] PFM_F_I2C_DAT   = 5'h0A;
	localparam logic [4:0] PFM_F_IR1_RX    = 5'h0B;
	localparam logic [4:0] PFM_F_IR1_TX    = 5'h0C;
	localparam logic [4:0] PFM_F_IR2_TX    = 5'h0D;
	localparam logic [4:0] PFM_F_ANALOG    = 5'h0F;
	localparam logic [4:0] PFM_F_PULSE0    = 5'h10;
	localparam logic [4:0] PFM_F_PULSE1    = 5'h11;
	localparam logic [4:0] PFM_F_DIAG      = 5'h12;
	localparam logic [4:0] PFM_F_U1_CTS    = 5'h13;
	localparam logic [4:0] PFM_F_U1_RTS    = 5'h14;
	localparam logic [4:0] PFM_F_U2_CTS    = 5'h15;
	localparam logic [4:0] PFM_F_U2_RTS    = 5'h16;
	localparam logic [4:0] PFM_F_PULSE2    = 5'h17;
	localparam logic [4:0] PFM_F_PULSE3    = 5'h18;
	localparam logic [4:0] PFM_F_PULSE4    = 5'h19;

	// input functions, in bit order of the resolved-input vectors
	localparam int         PFM_NIN = 8;
	localparam logic [4:0] PFM_IN_CODE [PFM_NIN] = '{
		PFM_F_U1_RX, PFM_F_U2_RX, PFM_F_SP_DI, PFM_F_I2C_CLK,
		PFM_F_I2C_DAT, PFM_F_IR1_RX, PFM_F_U1_CTS, PFM_F_U2_CTS};

	// ------------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] pull_select;
		logic [4:0] function_select;
	} pfm_mode_t;

	// levels the peripherals want on a pin; i2c lines are pull-low requests
	typedef struct packed {
		logic first_uart_transmit;
		logic second_uart_transmit;
		logic serial_periph_data_out;
		logic serial_periph_clock;
		logic serial_periph_enable;
		logic i2c_clock_low;
		logic i2c_data_low;
		logic first_infrared_transmit;
		logic second_infrared_transmit;
		logic pulse_output_zero;
		logic pulse_output_one;
		logic pulse_output_two;
		logic pulse_output_three;
		logic pulse_output_four;
		logic radio_diagnostic;
		logic first_uart_request_to_send;
		logic second_uart_request_to_send;
	} pfm_periph_out_t;

	// resolved input functions with a claim flag each
	typedef struct packed {
		logic [PFM_NIN-1:0] hit;
		logic [PFM_NIN-1:0] val;
	} pfm_in_route_t;

endpackage

// file: tb/pfm_pin_mux_chk.sv
// checker for the pin mode block: apb timing, pad and route relations
// assumes it is bound to pfm_pin_mux and sees only its ports
`timescale 1ns/1ps
module pfm_pin_mux_chk
	import pfm_pkg::*;
(
	// clock and reset
	input wire logic                sys_clk,
	input wire logic                arst_n,
	// apb
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [PFM_DW-1:0]   prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// pads and routing
	input wire logic [PFM_NPIN-1:0] pad_in,
	input wire logic [PFM_NPIN-1:0] pad_oe_n,
	input wire logic [PFM_NPIN-1:0] pull_up_en,
	input wire logic [PFM_NPIN-1:0] pull_down_en,
	input wire logic [PFM_NPIN-1:0] gpio_data_in,
	input wire pfm_in_route_t       route_in,
	input wire pfm_in_route_t       route_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	property p_ready_once;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	property p_err_read;
		pslverr && !pwrite |-> pready && prdata == '0;
	endproperty
	property p_rsv_zero;
		pready && !pwrite |-> prdata[31:10] == '0 && prdata[7:5] == '0;
	endproperty
	property p_pull_excl;
		(pull_up_en & pull_down_en) == '0;
	endproperty
	property p_drive_nopull;
		(~pad_oe_n & (pull_up_en | pull_down_en)) == '0;
	endproperty
	property p_reset_pull;
		$rose(arst_n) |-> pull_down_en == 3'h7 && pull_up_en == 3'h0 && pad_oe_n == 3'h7;
	endproperty
	property p_gpio_in;
		$past(arst_n) |-> gpio_data_in == $past(pad_in);
	endproperty
	// a claim from a higher-priority pin must pass through unchanged
	property p_route_prio;
		$past(arst_n) && $past(route_in.hit) != '0 |->
			(route_out.hit & $past(route_in.hit)) == $past(route_in.hit) &&
			((route_out.val ^ $past(route_in.val)) & $past(route_in.hit)) == '0;
	endproperty
	a_ready_once: assert property (p_ready_once)
		else $error("pready not a single cycle after setup");
	a_err_read: assert property (p_err_read)
		else $error("error read without pready or with data");
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved read bits not zero");
	a_pull_excl: assert property (p_pull_excl)
		else $error("pull-up and pull-down both on");
	a_drive_nopull: assert property (p_drive_nopull)
		else $error("driven pin has a pull enabled");
	a_reset_pull: assert property (p_reset_pull)
		else $error("pins not pulled-down inputs after reset");
	a_gpio_in: assert property (p_gpio_in)
		else $error("port input not one cycle behind pad");
	a_route_prio: assert property (p_route_prio)
		else $error("upstream input claim lost");
	c_err: cover property (pslverr);
	c_route: cover property (route_out.hit != '0);
	c_drive: cover property (pad_oe_n != 3'h7);
endmodule

bind pfm_pin_mux pfm_pin_mux_chk i_chk (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pad_in(pad_in), .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en),
	.pull_down_en(pull_down_en), .gpio_data_in(gpio_data_in), .route_in(route_in),
	.route_out(route_out));

// file: tb/pin_function_mode_select_bench.sv
// self-checking bench for the pin mode block: registers, pad modes, input priority
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module pin_function_mode_select_bench
	import pfm_pkg::*;
();
	logic                sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [PFM_AW-1:0]   paddr;
	logic [PFM_DW-1:0]   pwdata, prdata, rd;
	logic [3:0]          pstrb;
	logic [PFM_NPIN-1:0] pad_in, pad_out, pad_oe_n, pull_up_en, pull_down_en;
	logic [PFM_NPIN-1:0] gpio_data_out, gpio_data_in;
	pfm_periph_out_t     periph_out;
	pfm_in_route_t       route_in, route_out;
	logic [6:0]          mr [PFM_NPIN];
	int                  bad_count, tests_run;
	// periph_out bit driven by each function code, -1 where none
	int                  ob [32] = '{-1, -1, 16, -1, 15, -1, 14, 13, 12, 11, 10, -1, 9, 8,
		-1, -1, 7, 6, 2, -1, 1, -1, 0, 5, 4, 3, -1, -1, -1, -1, -1, -1};

	pfm_pin_mux i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
		.gpio_data_out(gpio_data_out), .gpio_data_in(gpio_data_in),
		.periph_out(periph_out), .route_in(route_in), .route_out(route_out));

	always #10 sys_clk = ~sys_clk;

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// waits for pready with no assumed latency; a stuck slave is left to the watchdog
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input int p, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, 12'h038 + 12'(8 * p), d, s);
		if (s[1])
			mr[p][6:5] = d[9:8];
		if (s[0])
			mr[p][4:0] = d[4:0];
	endtask
	task automatic rd_chk(input int p);
		apb(1'b0, 12'h038 + 12'(8 * p), 32'h0, 4'h0);
		check(rd, {22'h0, mr[p][6:5], 3'h0, mr[p][4:0]});
		check(er, 1'b0);
	endtask
	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		check(pad_oe_n, 3'h7);
		check({pull_up_en, pull_down_en}, 6'h07);
		for (int p = 0; p < PFM_NPIN; p++) begin
			mr[p] = {PFM_PULL_RST, PFM_FUNC_RST};
			rd_chk(p);
		end
	endtask
	task automatic chk_pin(input int p);
		logic [4:0] c;
		logic [1:0] u;
		int         b;
		c = mr[p][4:0];
		u = mr[p][6:5];
		b = ob[c];
		repeat (3) @(posedge sys_clk);
		if (c == PFM_F_GPIO && u == PFM_PULL_OUT) begin
			check({pad_oe_n[p], pad_out[p]}, {1'b0, gpio_data_out[p]});
			check({pull_up_en[p], pull_down_en[p]}, 2'h0);
		end else if (b == 10 || b == 11) begin
			check(pad_oe_n[p], !periph_out[b]);
			if (periph_out[b])
				check(pad_out[p], 1'b0);
		end else if (b >= 0) begin
			check({pad_oe_n[p], pad_out[p]}, {1'b0, periph_out[b]});
			check({pull_up_en[p], pull_down_en[p]}, 2'h0);
		end else begin
			check(pad_oe_n[p], 1'b1);
			check({pull_up_en[p], pull_down_en[p]}, c == PFM_F_ANALOG ? 2'h0 :
				{u == PFM_PULL_UP, u == PFM_PULL_DOWN});
		end
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		sys_clk       = 1'b0;
		arst_n        = 1'b0;
		psel          = 1'b0;
		penable       = 1'b0;
		pwrite        = 1'b0;
		paddr         = '0;
		pwdata        = '0;
		pstrb         = '0;
		pad_in        = '0;
		gpio_data_out = '0;
		periph_out    = '0;
		route_in      = '0;
		bad_count     = 0;
		tests_run     = 0;
		void'($urandom(34140));
		do_reset();
		for (int i = 0; i < 24; i++) begin
			wr(i % 3, $urandom, 4'($urandom));
			rd_chk(i % 3);
		end
		apb(1'b1, 12'h03C, 32'hFFFFFFFF, 4'hF);
		check(er, 1'b1);
		apb(1'b0, 12'h03C, 32'h0, 4'h0);
		check({er, rd[30:0]}, 32'h80000000);
		// the refused write must have left every mode register untouched
		for (int p = 0; p < PFM_NPIN; p++)
			rd_chk(p);
		for (int p = 0; p < PFM_NPIN; p++) begin
			for (int c = 0; c < 32; c++) begin
				periph_out    <= 17'($urandom);
				gpio_data_out <= 3'($urandom);
				wr(p, {22'h0, 2'($urandom), 3'h0, 5'(c)}, 4'h3);
				chk_pin(p);
			end
		end
		// pins 5 and 6 claim the same input, pin 5 must win unless upstream claims
		wr(0, 32'h0, 4'h3);
		for (int k = 0; k < PFM_NIN; k++) begin
			wr(1, {27'h0, PFM_IN_CODE[k]}, 4'h1);
			wr(2, {27'h0, PFM_IN_CODE[k]}, 4'h1);
			for (int j = 0; j < 4; j++) begin
				pad_in   <= (j == 0) ? 3'h2 : 3'($urandom);
				route_in <= (j == 0) ? 16'h0 : 16'($urandom);
				repeat (3) @(posedge sys_clk);
				check(route_out.hit, route_in.hit | (8'h01 << k));
				check(route_out.val[k], route_in.hit[k] ? route_in.val[k] : pad_in[1]);
			end
		end
		do_reset();
		conclude();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		conclude();
	end
endmodule

// file: verilog/pfm_pin_mux.sv
// pin function and mode select for port 0 pins 4 to 6, with APB register access
// assumes a zero-wait APB master, synchronous pad inputs, and a priority chain
// in which pins 0..3 feed in from above and pin 7 / port 1 sit below
`timescale 1ns/1ps

// Function
// - bits 9:8 set the pin as input without pull, with pull-up, with pull-down, or as an output.
// - with the analog converter function selected the pull field has no effect on the pin.
// - after reset the pull field holds 2, an input with pull-down.
// - function 0 is a plain port pin whose direction and pull come from the pull field.
// - functions 1 to 13 route the two UARTs, the serial peripheral, I2C and the IrDA lines.
// - function 15 connects the analog converter input, valid only on port 0 pins 3 to 0.
// - functions 16, 17 and 23 to 25 route pulse outputs zero to four.
// - function 18 drives the radio diagnostic signal, available on port 0 pins 7 to 0.
// - functions 19 to 22 carry the UART flow-control lines.
// - an input selected on several pins is taken from the lowest-index pin of a port.
// - a selecting pin on the first port beats any pin on the second port.
module pfm_pin_mux
	import pfm_pkg::*;
(
	// clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    arst_n,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [PFM_AW-1:0]       paddr,
	input  wire logic [PFM_DW-1:0]       pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [PFM_DW-1:0]       prdata,
	output logic                         pready,
	output logic                         pslverr,
	// pads
	input  wire logic [PFM_NPIN-1:0]     pad_in,
	output logic      [PFM_NPIN-1:0]     pad_out,
	output logic      [PFM_NPIN-1:0]     pad_oe_n,
	output logic      [PFM_NPIN-1:0]     pull_up_en,
	output logic      [PFM_NPIN-1:0]     pull_down_en,
	// port data and peripheral drive
	input  wire logic [PFM_NPIN-1:0]     gpio_data_out,
	output logic      [PFM_NPIN-1:0]     gpio_data_in,
	input  wire pfm_periph_out_t         periph_out,
	// input routing chain
	input  wire pfm_in_route_t           route_in,
	output pfm_in_route_t                route_out
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		pfm_mode_t [PFM_NPIN-1:0] mode;
		logic [PFM_DW-1:0]        rdata;
		logic                     ready;
		logic                     slverr;
		logic [PFM_NPIN-1:0]      pad_out;
		logic [PFM_NPIN-1:0]      pad_oe_n;
		logic [PFM_NPIN-1:0]      pull_up;
		logic [PFM_NPIN-1:0]      pull_down;
		logic [PFM_NPIN-1:0]      gpio_in;
		pfm_in_route_t            route;
	} pfm_state_t;

	pfm_state_t state_r;
	pfm_state_t state_nxt;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [PFM_NPIN-1:0] addr_hit(input logic [PFM_AW-1:0] a);
		logic [PFM_NPIN-1:0] h;
		h    = '0;
		h[0] = (a[PFM_AW-1:2] == PFM_IDX_PIN4[PFM_IDX_BITS-1:0]);
		h[1] = (a[PFM_AW-1:2] == PFM_IDX_PIN5[PFM_IDX_BITS-1:0]);
		h[2] = (a[PFM_AW-1:2] == PFM_IDX_PIN6[PFM_IDX_BITS-1:0]);
		return h;
	endfunction

	// drive request for one pin: {enable, level}
	function automatic logic [1:0] periph_drive(input logic [4:0] f, input int pin);
		logic [1:0] d;
		d = 2'b00;
		unique case (f)
			PFM_F_U1_TX:   d = {1'b1, periph_out.first_uart_transmit};
			PFM_F_U2_TX:   d = {1'b1, periph_out.second_uart_transmit};
			PFM_F_SP_DO:   d = {1'b1, periph_out.serial_periph_data_out};
			PFM_F_SP_CLK:  d = {1'b1, periph_out.serial_periph_clock};
			PFM_F_SP_EN:   d = {1'b1, periph_out.serial_periph_enable};
			// open drain: drive low only while the controller pulls low
			PFM_F_I2C_CLK: d = {periph_out.i2c_clock_low, 1'b0};
			PFM_F_I2C_DAT: d = {periph_out.i2c_data_low, 1'b0};
			PFM_F_IR1_TX:  d = {1'b1, periph_out.first_infrared_transmit};
			PFM_F_IR2_TX:  d = {1'b1, periph_out.second_infrared_transmit};
			PFM_F_PULSE0:  d = {1'b1, periph_out.pulse_output_zero};
			PFM_F_PULSE1:  d = {1'b1, periph_out.pulse_output_one};
			PFM_F_PULSE2:  d = {1'b1, periph_out.pulse_output_two};
			PFM_F_PULSE3:  d = {1'b1, periph_out.pulse_output_three};
			PFM_F_PULSE4:  d = {1'b1, periph_out.pulse_output_four};
			PFM_F_DIAG: begin
				if (pin <= PFM_DIAG_MAX_PIN) begin
					d = {1'b1, periph_out.radio_diagnostic};
				end
			end
			PFM_F_U1_RTS:  d = {1'b1, periph_out.first_uart_request_to_send};
			PFM_F_U2_RTS:  d = {1'b1, periph_out.second_uart_request_to_send};
			default:       d = 2'b00;
		endcase
		return d;
	endfunction

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [PFM_NPIN-1:0] hit;
		logic                setup;
		logic                wr_en;
		logic [4:0]          f;
		logic [1:0]          pl;
		logic [1:0]          drv;
		logic                found;
		logic                fval;
		hit       = addr_hit(paddr);
		setup     = psel && !penable;
		wr_en     = psel && penable && pwrite && state_r.ready && !state_r.slverr;
		f         = '0;
		pl        = '0;
		drv       = '0;
		found     = 1'b0;
		fval      = 1'b0;
		state_nxt = state_r;

		// bus: answer in the first access cycle; read data is captured in setup, write data in that access cycle
		state_nxt.ready  = setup;
		state_nxt.slverr = setup && (hit == '0);
		if (setup) begin
			state_nxt.rdata = '0;
			for (int p = 0; p < PFM_NPIN; p++) begin
				if (hit[p] && !pwrite) begin
					state_nxt.rdata[PFM_PULL_MSB:PFM_PULL_LSB] = state_r.mode[p].pull_select;
					state_nxt.rdata[PFM_FUNC_MSB:PFM_FUNC_LSB] = state_r.mode[p].function_select;
				end
			end
		end
		// reserved bits are not stored, so they read zero
		for (int p = 0; p < PFM_NPIN; p++) begin
			if (wr_en && hit[p]) begin
				if (pstrb[1]) begin
					state_nxt.mode[p].pull_select = pwdata[PFM_PULL_MSB:PFM_PULL_LSB];
				end
				if (pstrb[0]) begin
					state_nxt.mode[p].function_select = pwdata[PFM_FUNC_MSB:PFM_FUNC_LSB];
				end
			end
		end

		// pin drive and pulls
		for (int p = 0; p < PFM_NPIN; p++) begin
			f = state_r.mode[p].function_select;
			pl = state_r.mode[p].pull_select;
			state_nxt.pad_out[p]   = 1'b0;
			state_nxt.pad_oe_n[p]  = 1'b1;
			state_nxt.pull_up[p]   = (pl == PFM_PULL_UP);
			state_nxt.pull_down[p] = (pl == PFM_PULL_DOWN);
			if (f == PFM_F_GPIO) begin
				if (pl == PFM_PULL_OUT) begin
					state_nxt.pad_out[p]  = gpio_data_out[p];
					state_nxt.pad_oe_n[p] = 1'b0;
				end
			end else if (f == PFM_F_ANALOG) begin
				// pull field ignored; no analog path exists on pins above 3
				state_nxt.pull_up[p]   = 1'b0;
				state_nxt.pull_down[p] = 1'b0;
			end else begin
				drv = periph_drive(f, PFM_FIRST_PIN + p);
				if (drv[1]) begin
					state_nxt.pad_out[p]   = drv[0];
					state_nxt.pad_oe_n[p]  = 1'b0;
					state_nxt.pull_up[p]   = 1'b0;
					state_nxt.pull_down[p] = 1'b0;
				end
			end
			state_nxt.gpio_in[p] = pad_in[p];
		end

		// input routing: higher chain wins, then lowest pin here
		for (int k = 0; k < PFM_NIN; k++) begin
			found = 1'b0;
			fval  = 1'b0;
			for (int p = 0; p < PFM_NPIN; p++) begin
				if (!found && state_r.mode[p].function_select == PFM_IN_CODE[k]) begin
					found = 1'b1;
					fval  = pad_in[p];
				end
			end
			state_nxt.route.hit[k] = route_in.hit[k] | found;
			state_nxt.route.val[k] = route_in.hit[k] ? route_in.val[k] : fval;
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int p = 0; p < PFM_NPIN; p++) begin
				state_r.mode[p].pull_select     <= PFM_PULL_RST;
				state_r.mode[p].function_select <= PFM_FUNC_RST;
			end
			state_r.rdata     <= '0;
			state_r.ready     <= 1'b0;
			state_r.slverr    <= 1'b0;
			state_r.pad_out   <= '0;
			state_r.pad_oe_n  <= '1;
			state_r.pull_up   <= '0;
			state_r.pull_down <= '1;
			state_r.gpio_in   <= '0;
			state_r.route     <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign prdata       = state_r.rdata;
	assign pready       = state_r.ready;
	assign pslverr      = state_r.slverr;
	assign pad_out      = state_r.pad_out;
	assign pad_oe_n     = state_r.pad_oe_n;
	assign pull_up_en   = state_r.pull_up;
	assign pull_down_en = state_r.pull_down;
	assign gpio_data_in = state_r.gpio_in;
	assign route_out    = state_r.route;

endmodule
